// ---- bench/tb_table_pointer_move_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_table_pointer_move_engine;
  localparam logic [15:0] B = 16'h0010;
  localparam logic [15:0] X = 16'h0040;
  logic mclk, nrst, cmd_valid, cmd_ready, scan_end, done, flag;
  tpm_pkg::tpm_cmd_t cmd;
  tpm_pkg::tpm_mem_t mem;
  logic [15:0] rdata;
  int mismatches, comparisons;
  tpm_engine u_tpm_engine (.mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .scan_end(scan_end), .done(done),
    .pointer_edge_flag(flag), .mem(mem), .mem_rdata(rdata));
  tpm_mem_model u_tpm_mem_model (.mclk(mclk), .mem(mem), .mem_rdata(rdata));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ------
  // tasks
  // ------
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      $display("unexpected at %0t got %h exp %h", $time, g, e);
      mismatches++;
    end
  endtask
  task automatic run(input tpm_pkg::tpm_op_t op, input logic en);
    int n;
    @(negedge mclk);
    cmd = '{op, en, 8'h03, B, X};
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n == 20) begin
      mismatches++;
      conclude();
    end
    // pointer write-back lands one edge after done
    @(negedge mclk);
  endtask
  task automatic step(input tpm_pkg::tpm_op_t op, input logic [15:0] off,
      input logic [15:0] ptr, input logic fl);
    run(op, 1'b1);
    if (op == tpm_pkg::SOURCE_TO_TABLE_OP)
      chk(u_tpm_mem_model.ram[B + off], u_tpm_mem_model.ram[X]);
    else
      chk(u_tpm_mem_model.ram[X], u_tpm_mem_model.ram[B + off]);
    chk(u_tpm_mem_model.ram[B], ptr);
    chk(16'(flag), 16'(fl));
  endtask
  task automatic t_ttd;
    u_tpm_mem_model.ram[B] = 16'h0000;
    step(tpm_pkg::TABLE_TO_DEST_OP, 16'h1, 16'h1, 1'b0);
    step(tpm_pkg::TABLE_TO_DEST_OP, 16'h2, 16'h2, 1'b0);
    step(tpm_pkg::TABLE_TO_DEST_OP, 16'h3, 16'h3, 1'b1);
    @(negedge mclk);
    scan_end = 1'b1;
    @(negedge mclk);
    scan_end = 1'b0;
    chk(16'(flag), 16'h0);
    step(tpm_pkg::TABLE_TO_DEST_OP, 16'h1, 16'h1, 1'b0);
  endtask
  task automatic t_rfb;
    u_tpm_mem_model.ram[B] = 16'h0002;
    step(tpm_pkg::REMOVE_BOTTOM_OP, 16'h2, 16'h1, 1'b0);
    step(tpm_pkg::REMOVE_BOTTOM_OP, 16'h1, 16'h0, 1'b1);
    u_tpm_mem_model.ram[X] = 16'h1234;
    scan_end = 1'b1;
    @(negedge mclk);
    scan_end = 1'b0;
    chk(16'(flag), 16'h0);
    run(tpm_pkg::REMOVE_BOTTOM_OP, 1'b1);
    chk(u_tpm_mem_model.ram[X], 16'h1234);
    chk(u_tpm_mem_model.ram[B], 16'h0000);
    chk(16'(flag), 16'h1);
  endtask
  task automatic t_stt;
    u_tpm_mem_model.ram[B] = 16'h0002;
    u_tpm_mem_model.ram[X] = 16'h5a5a;
    step(tpm_pkg::SOURCE_TO_TABLE_OP, 16'h3, 16'h3, 1'b1);
    u_tpm_mem_model.ram[X] = 16'ha5a5;
    step(tpm_pkg::SOURCE_TO_TABLE_OP, 16'h1, 16'h1, 1'b0);
  endtask
  task automatic t_skip;
    u_tpm_mem_model.ram[B] = 16'h0001;
    run(tpm_pkg::TABLE_TO_DEST_OP, 1'b0);
    chk(u_tpm_mem_model.ram[B], 16'h0001);
    run(tpm_pkg::NO_OP, 1'b1);
    chk(u_tpm_mem_model.ram[B], 16'h0001);
  endtask
  initial begin
    nrst = 1'b0;
    cmd_valid = 1'b0;
    scan_end = 1'b0;
    cmd = '0;
    mismatches = 0;
    comparisons = 0;
    for (int i = 0; i < 256; i++) u_tpm_mem_model.ram[i] = 16'hc000 + 16'(i);
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
    t_ttd();
    t_rfb();
    t_stt();
    t_skip();
    conclude();
  end
endmodule
`default_nettype wire

// ---- bench/tpm_engine_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpm_engine_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // request
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire tpm_pkg::tpm_cmd_t cmd,
  input wire logic scan_end,
  input wire logic done,
  input wire logic pointer_edge_flag,
  // memory
  input wire tpm_pkg::tpm_mem_t mem,
  input wire logic [15:0] mem_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic take, tk;
  assign take = cmd_valid && cmd_ready;
  assign tk = take && cmd.enable && cmd.op != tpm_pkg::NO_OP;
  // ------
  // checks
  // ------
  ptr_read_a: assert property (tk |=>
    mem.re && mem.addr == $past(cmd.base)) else $error("bad ptr read");
  done_bound_a: assert property (tk |-> ##[4:7] done)
    else $error("no done");
  skip_done_a: assert property (take && !tk |=> done)
    else $error("skip slow");
  ready_done_a: assert property (done |-> cmd_ready)
    else $error("busy at done");
  move_data_a: assert property (mem.we && !done |->
    mem.wdata == $past(mem_rdata)) else $error("bad moved word");
  write_order_a: assert property (mem.we && !done |=>
    done && mem.we) else $error("ptr write late");
  flag_clear_a: assert property (scan_end |=>
    !pointer_edge_flag || done) else $error("flag kept");
  flag_hold_a: assert property (!scan_end ##1 !done |->
    $stable(pointer_edge_flag)) else $error("flag moved");
  rfb_zero_a: assert property ((tk && cmd.op ==
    tpm_pkg::REMOVE_BOTTOM_OP) ##3 (mem_rdata == 16'h0000) |=>
    done && pointer_edge_flag && !mem.we) else $error("zero moved");
  cover property (tk && cmd.op == tpm_pkg::SOURCE_TO_TABLE_OP);
  cover property (done && pointer_edge_flag);
  cover property (scan_end && pointer_edge_flag);
endmodule
bind tpm_engine tpm_engine_monitor u_mon (.mclk(mclk), .nrst(nrst),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
  .scan_end(scan_end), .done(done), .pointer_edge_flag(pointer_edge_flag),
  .mem(mem), .mem_rdata(mem_rdata));
`default_nettype wire

// ---- bench/tpm_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpm_mem_model (
  // clock
  input wire logic mclk,
  // engine side
  input wire tpm_pkg::tpm_mem_t mem,
  output logic [15:0] mem_rdata
);
  logic [15:0] ram [256];
  logic hold;
  // read word held two cycles, then inverted every cycle, so the stale word comes back on alternate cycles
  always @(posedge mclk) begin
    hold <= mem.re;
    if (mem.re) begin
      mem_rdata <= ram[mem.addr[7:0]];
    end else if (!hold) begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem.we) begin
      ram[mem.addr[7:0]] <= mem.wdata;
    end
  end
endmodule
`default_nettype wire

// ---- hw/tpm_engine.sv ----
`timescale 1ns/1ps
`default_nettype none

// Contract
// - table-to-destination copies slot at pointer plus one to destination, then pointer plus one.
// - first table word is the pointer; data starts at the next word.
// - each operation runs once per scan while its enable stays true.
// - table-to-destination pointer wraps to one, not zero, at the length.
// - table-to-destination and source-to-table: pointer zero or equal to length selects the first data word.
// - edge flag holds only until next flag-using operation or scan end.
// - remove-bottom copies pointed slot to destination, then pointer minus one.
// - remove-bottom moves nothing once the pointer is zero.
// - remove-bottom raises the edge flag when the pointer is zero.
// - remove-bottom pointer n addresses the word n after the pointer.
// - source-to-table stores source at slot of pointer plus one, increments, wraps to one.
// - source-to-table raises the edge flag when the incremented pointer equals length.
module tpm_engine (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // operation request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire tpm_pkg::tpm_cmd_t cmd,
  input wire logic scan_end,
  output logic done,
  output logic pointer_edge_flag,
  // word memory
  output tpm_pkg::tpm_mem_t mem,
  input wire logic [tpm_pkg::DATA_W-1:0] mem_rdata
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;
  logic next_rst_meta;
  logic next_rst_n;

  // only the second stage feeds the sequencer reset
  always_comb begin
    next_rst_meta = 1'b1;
    next_rst_n = rst_meta;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= next_rst_meta;
      rst_n <= next_rst_n;
    end
  end

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_PTR_RD,
    S_PTR_CAP,
    S_DAT_RD,
    S_DAT_CAP,
    S_DAT_WR,
    S_PTR_WR
  } tpm_state_t;

  tpm_state_t state;
  tpm_state_t next_state;
  tpm_pkg::tpm_cmd_t cur;
  tpm_pkg::tpm_cmd_t next_cur;
  logic [tpm_pkg::DATA_W-1:0] ptr;
  logic [tpm_pkg::DATA_W-1:0] next_ptr_q;
  tpm_pkg::tpm_mem_t next_mem;
  logic next_done;
  logic next_flag;
  logic flag_load;

  logic move_ok;
  logic edge_hit;
  logic [tpm_pkg::DATA_W-1:0] slot_off;
  logic [tpm_pkg::DATA_W-1:0] step_ptr;
  logic [tpm_pkg::ADDR_W-1:0] slot_addr;

  tpm_ptr_step u_step (
    .op(cur.op),
    .ptr(ptr),
    .len(cur.len),
    .move_ok(move_ok),
    .slot_off(slot_off),
    .next_ptr(step_ptr),
    .edge_hit(edge_hit)
  );

  assign slot_addr = tpm_pkg::addr_add(cur.base, slot_off);
  assign cmd_ready = (state == S_IDLE);
  // flag-using completions: out-of-range finish or pointer write-back
  assign flag_load = (state == S_PTR_WR) ||
    (state == S_DAT_RD && !move_ok);

  // source-to-table runs the data move in the opposite direction
  function automatic logic fills_table(input tpm_pkg::tpm_op_t op);
    fills_table = (op == tpm_pkg::SOURCE_TO_TABLE_OP);
  endfunction

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_ptr_q = ptr;
    next_mem = '0;
    next_done = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (cmd_valid) begin
          next_cur = cmd;
          if (cmd.enable && cmd.op != tpm_pkg::NO_OP) begin
            next_state = S_PTR_RD;
            next_mem.re = 1'b1;
            next_mem.addr = cmd.base;
          end else begin
            // disabled rung: nothing moves, flag untouched
            next_done = 1'b1;
          end
        end
      end
      S_PTR_RD: begin
        next_state = S_PTR_CAP;
      end
      S_PTR_CAP: begin
        next_ptr_q = mem_rdata;
        next_state = S_DAT_RD;
      end
      S_DAT_RD: begin
        if (move_ok) begin
          next_mem.re = 1'b1;
          if (fills_table(cur.op)) begin
            next_mem.addr = cur.xfer;
          end else begin
            next_mem.addr = slot_addr;
          end
          next_state = S_DAT_CAP;
        end else begin
          // pointer out of range: report and finish, pointer kept
          next_done = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_DAT_CAP: begin
        next_state = S_DAT_WR;
      end
      S_DAT_WR: begin
        next_mem.we = 1'b1;
        next_mem.wdata = mem_rdata;
        if (fills_table(cur.op)) begin
          next_mem.addr = slot_addr;
        end else begin
          next_mem.addr = cur.xfer;
        end
        next_state = S_PTR_WR;
      end
      S_PTR_WR: begin
        // pointer written only after the data word has landed
        next_mem.we = 1'b1;
        next_mem.addr = cur.base;
        next_mem.wdata = step_ptr;
        next_ptr_q = step_ptr;
        next_done = 1'b1;
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // edge flag
  // ----------------------------------------
  // a completing operation wins over scan end in the same cycle
  always_comb begin
    next_flag = pointer_edge_flag;
    if (scan_end) begin
      next_flag = 1'b0;
    end
    if (flag_load) begin
      next_flag = edge_hit;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      cur <= '0;
      ptr <= tpm_pkg::PTR_ZERO;
      mem <= '0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      ptr <= next_ptr_q;
      mem <= next_mem;
      done <= next_done;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pointer_edge_flag <= 1'b0;
    end else begin
      pointer_edge_flag <= next_flag;
    end
  end

endmodule

`default_nettype wire

// ---- hw/tpm_pkg.sv ----
package tpm_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int LEN_W = 8;

  // ----------------------------------------
  // pointer and reset constants
  // ----------------------------------------
  localparam logic [DATA_W-1:0] PTR_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] PTR_ONE = 16'h0001;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    TABLE_TO_DEST_OP,
    REMOVE_BOTTOM_OP,
    SOURCE_TO_TABLE_OP,
    NO_OP
  } tpm_op_t;

  typedef struct packed {
    tpm_op_t op;
    logic enable;
    logic [LEN_W-1:0] len;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] xfer;
  } tpm_cmd_t;

  typedef struct packed {
    logic re;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tpm_mem_t;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [ADDR_W-1:0] addr_add(
    input logic [ADDR_W-1:0] base,
    input logic [DATA_W-1:0] off
  );
    addr_add = ADDR_W'(base + off);
  endfunction

endpackage

// ---- hw/tpm_ptr_step.sv ----
`timescale 1ns/1ps
`default_nettype none

module tpm_ptr_step (
  // operation
  input wire tpm_pkg::tpm_op_t op,
  input wire logic [tpm_pkg::DATA_W-1:0] ptr,
  input wire logic [tpm_pkg::LEN_W-1:0] len,
  // results
  output logic move_ok,
  output logic [tpm_pkg::DATA_W-1:0] slot_off,
  output logic [tpm_pkg::DATA_W-1:0] next_ptr,
  output logic edge_hit
);

  logic [tpm_pkg::DATA_W-1:0] len_w;

  assign len_w = tpm_pkg::DATA_W'(len);

  always_comb begin
    move_ok = 1'b0;
    slot_off = tpm_pkg::PTR_ONE;
    next_ptr = ptr;
    edge_hit = 1'b0;
    unique case (op)
      tpm_pkg::TABLE_TO_DEST_OP,
      tpm_pkg::SOURCE_TO_TABLE_OP: begin
        // a pointer past the table end moves nothing
        move_ok = (ptr <= len_w);
        if (ptr == tpm_pkg::PTR_ZERO || ptr == len_w) begin
          slot_off = tpm_pkg::PTR_ONE;
        end else begin
          slot_off = tpm_pkg::DATA_W'(ptr + tpm_pkg::PTR_ONE);
        end
        if (ptr >= len_w) begin
          next_ptr = tpm_pkg::PTR_ONE;
        end else begin
          next_ptr = tpm_pkg::DATA_W'(ptr + tpm_pkg::PTR_ONE);
        end
        edge_hit = move_ok && (next_ptr == len_w);
      end
      tpm_pkg::REMOVE_BOTTOM_OP: begin
        move_ok = (ptr != tpm_pkg::PTR_ZERO) && (ptr <= len_w);
        slot_off = ptr;
        if (move_ok) begin
          next_ptr = tpm_pkg::DATA_W'(ptr - tpm_pkg::PTR_ONE);
        end
        edge_hit = (next_ptr == tpm_pkg::PTR_ZERO);
      end
      tpm_pkg::NO_OP: begin
        move_ok = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire
